// [rtl/dcsf_cfg.svh]
// Constants of the channel sequencer: status bit positions, reset values and field codes.
// Included by every module file of the sequencer; holds definitions only.
`ifndef DCSF_CFG_SVH
`define DCSF_CFG_SVH

`define SR_USER_FLAG_0 4'd0
`define SR_USER_FLAG_3 4'd3
`define SR_REPEAT_NEG 4'd8
`define SR_WORD_NEG 4'd9
`define SR_WINDOW_HIT 4'd10
`define SR_AREA_OVERLAP 4'd11
`define SR_HALT 4'd15
`define SR_RESET_VALUE 16'h8000

`define GRP_NOP 4'h0
`define GRP_LOOP 4'h1
`define GRP_COMBO 4'h2
`define GRP_COND 4'h3
`define GRP_LOAD 4'h4
`define GRP_JUMP 4'h5
`define GRP_EXEC_AT 4'h6
`define GRP_DRAW 4'h7

`define NOP_PLAIN 4'h0
`define NOP_HALT 4'h1

`define LOOP_NEG_REPEAT 2'h0
`define LOOP_NEG_WORD 2'h1
`define LOOP_POS_REPEAT 2'h2
`define LOOP_POS_WORD 2'h3

`define COND_NONE 2'h0
`define COND_RAISE 2'h1
`define COND_ZERO 2'h2
`define COND_INVERT 2'h3

`define REG_READ_PTR 3'h0
`define REG_REPEAT 3'h1
`define REG_WORD 3'h2
`define REG_STATUS 3'h3

`define COUNT_MINUS_ONE 16'hFFFF
`define COUNT_ONE 16'h0001
`define COUNT_ZERO 16'h0000

`endif

// [rtl/dcsf_pkg.sv]
// Types shared by the channel sequencer files.
// Assumes nothing of its surroundings.
package dcsf_pkg;

	typedef struct packed {
		logic [3:0] group;
		logic [3:0] op;
		logic [3:0] cond;
		logic [2:0] reg_sel;
		logic invert;
		logic [15:0] data;
	} instr_t;

	typedef struct packed {
		logic seq;
		logic rep;
		logic exec;
	} suffix_t;

	typedef struct packed {
		logic clear_halt;
		logic clear_hit;
	} host_ctl_t;

	typedef enum logic [1:0] {
		MODE_SEQ = 2'b00,
		MODE_REPEAT = 2'b01,
		MODE_EXEC = 2'b11
	} mode_t;

	typedef enum logic [2:0] {
		ST_FETCH = 3'b000,
		ST_EXEC = 3'b001,
		ST_REPEAT = 3'b011,
		ST_SLOW = 3'b010,
		ST_HALT = 3'b100
	} state_t;

endpackage

// [rtl/loop_counter.sv]
// Loadable up-counter used for the repeat and word counts.
// Assumes load and increment come from logic on the same clock.
`timescale 1ns/1ps
`include "dcsf_cfg.svh"
module loop_counter #(
	parameter int WIDTH = 16
) (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_load,
	input wire logic [WIDTH-1:0] i_load_value,
	input wire logic i_increment,
	output logic [WIDTH-1:0] o_count,
	output logic o_changed
);

	always_ff @(posedge i_sys_clk)
	begin
		if (i_reset)
			o_count <= '0;
		else if (i_load)
			o_count <= i_load_value;
		else if (i_increment)
			o_count <= o_count + WIDTH'(1);
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_reset)
			o_changed <= 1'b0;
		else
			o_changed <= i_load | i_increment;
	end

endmodule // loop_counter

// [rtl/instr_fields.sv]
// Splits an instruction word into fields and the mode suffixes it carries.
// Assumes a 32-bit instruction word from the host memory.
`timescale 1ns/1ps
`include "dcsf_cfg.svh"
module instr_fields
	import dcsf_pkg::*;
(
	input wire logic [31:0] i_word,
	output instr_t o_fields,
	output suffix_t o_suffix
);

	logic suffixable;

	assign o_fields = instr_t'(i_word);
	assign suffixable = (o_fields.group == `GRP_NOP) || (o_fields.group[3:2] == 2'b01);
	assign o_suffix.seq = suffixable & o_fields.op[2];
	assign o_suffix.rep = suffixable & o_fields.op[1];
	assign o_suffix.exec = (suffixable & o_fields.op[0]) | (o_fields.group == `GRP_EXEC_AT);

endmodule // instr_fields

// [rtl/display_channel_sequencer_flags.sv]
// Instruction sequencer and condition status register of a display channel control unit.
// Assumes a host memory port answering a fetch with a one-cycle acknowledge, and
// clipping-unit event inputs that come from logic on the same clock.
//
// What this block does
// - Execute suffix: finish instruction, then execute mode.
// - Execute no-op only enters execute mode.
// - After executed instruction, resume after entering one.
// - Repeat plus execute suffix: repeat, then chain.
// - Negative loop jump increments repeat count, branches.
// - Negative loop jumps test count before incrementing; positive ones test it after.
// - Word-count loops and positive loop jumps.
// - Repeat suffix repeats the draw strobe of a draw instruction until count runs out.
// - Sequential suffix returns to normal fetching.
// - Conditions are single bits of status.
// - Condition ops raise, zero or invert.
// - Repeat-negative flag tracks count below minus one.
// - Zero on negative flag ignored; others increment.
// - Negative loop jump equals conditional jump plus raise.
// - Word-negative flag follows word count likewise.
// - Window hit sticky until zeroed.
// - Area overlap driven by clipping unit.
// - Halt flag stops instruction execution.
// - Status loadable; unit-owned bits get overwritten.
// - Host control word clears hit and halt.
// - Combined ops test condition before modifying.
// - Combined load or jump beats separate sequence.
`timescale 1ns/1ps
`include "dcsf_cfg.svh"
module display_channel_sequencer_flags
	import dcsf_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_reset,
	output logic o_mem_req,
	output logic [15:0] o_mem_addr,
	input wire logic i_mem_ack,
	input wire logic [31:0] i_mem_rdata,
	input wire logic i_host_ctl_strobe,
	input wire host_ctl_t i_host_ctl,
	input wire logic i_window_hit,
	input wire logic i_area_update,
	input wire logic i_area_overlap,
	input wire logic i_internal_halt,
	output logic [15:0] o_status,
	output mode_t o_mode,
	output logic o_draw_strobe
);

	state_t state;
	instr_t ir;
	instr_t fetched;
	suffix_t sfx;
	suffix_t fetched_sfx;
	logic [15:0] instruction_pointer;
	logic [15:0] read_pointer_register;
	logic [15:0] repeat_count;
	logic [15:0] word_count;
	logic [15:0] repeat_plus;
	logic [15:0] word_plus;
	logic [15:0] status;
	logic repeat_changed;
	logic word_changed;
	logic from_read_ptr;
	logic repeat_more;
	logic word_more;
	logic fetch_done;
	logic cond_now;
	logic take;
	logic do_jump;
	logic do_load;
	logic halt_set;
	logic slow;
	logic draw;
	logic repeat_inc;
	logic word_inc;
	logic [1:0] cond_op;

	instr_fields u_fields (
		.i_word(i_mem_rdata),
		.o_fields(fetched),
		.o_suffix(fetched_sfx)
	);

	loop_counter #(.WIDTH(16)) u_repeat (
		.i_sys_clk(i_sys_clk),
		.i_reset(i_reset),
		.i_load(do_load && ir.reg_sel == `REG_REPEAT),
		.i_load_value(ir.data),
		.i_increment(repeat_inc),
		.o_count(repeat_count),
		.o_changed(repeat_changed)
	);

	loop_counter #(.WIDTH(16)) u_word (
		.i_sys_clk(i_sys_clk),
		.i_reset(i_reset),
		.i_load(do_load && ir.reg_sel == `REG_WORD),
		.i_load_value(ir.data),
		.i_increment(word_inc),
		.o_count(word_count),
		.o_changed(word_changed)
	);

	assign repeat_more = $signed(repeat_count) < $signed(`COUNT_MINUS_ONE);
	assign word_more = $signed(word_count) < $signed(`COUNT_MINUS_ONE);
	assign repeat_plus = repeat_count + `COUNT_ONE;
	assign word_plus = word_count + `COUNT_ONE;
	assign fetch_done = (state == ST_FETCH) && o_mem_req && i_mem_ack;
	assign cond_now = status[ir.cond] ^ ir.invert;
	assign o_status = status;

	// Decodes the held instruction into actions for the current cycle.
	always_comb
	begin
		take = 1'b0;
		do_jump = 1'b0;
		do_load = 1'b0;
		halt_set = 1'b0;
		slow = 1'b0;
		draw = 1'b0;
		repeat_inc = 1'b0;
		word_inc = 1'b0;
		cond_op = `COND_NONE;
		if (state == ST_EXEC)
		begin
			unique case (ir.group)
				`GRP_NOP:
					halt_set = (ir.cond == `NOP_HALT);
				`GRP_LOOP:
				begin
					unique case (ir.op[1:0])
						`LOOP_NEG_REPEAT:
							take = repeat_more;
						`LOOP_NEG_WORD:
							take = word_more;
						`LOOP_POS_REPEAT:
							take = !repeat_plus[15] && repeat_plus != `COUNT_ZERO;
						`LOOP_POS_WORD:
							take = !word_plus[15] && word_plus != `COUNT_ZERO;
					endcase
					repeat_inc = !ir.op[0];
					word_inc = ir.op[0];
					do_jump = take;
				end
				`GRP_COMBO:
				begin
					take = ir.op[2] ? cond_now : 1'b1;
					do_jump = take && ir.op[3];
					do_load = take && !ir.op[3];
					cond_op = ir.op[1:0];
					slow = !ir.op[2] && ir.op[1:0] == `COND_NONE;
				end
				`GRP_COND:
					cond_op = ir.op[1:0];
				`GRP_LOAD:
					do_load = 1'b1;
				`GRP_JUMP:
					do_jump = 1'b1;
				`GRP_EXEC_AT:
					do_load = 1'b0;
				`GRP_DRAW:
				begin
					do_load = 1'b1;
					draw = 1'b1;
				end
				default:
					take = 1'b0;
			endcase
			if (cond_op != `COND_NONE && cond_op != `COND_ZERO)
			begin
				if (ir.cond == `SR_REPEAT_NEG)
					repeat_inc = 1'b1;
				if (ir.cond == `SR_WORD_NEG)
					word_inc = 1'b1;
			end
			if (cond_op == `COND_RAISE && ir.cond == `SR_HALT)
				halt_set = 1'b1;
		end
		else if (state == ST_REPEAT)
		begin
			repeat_inc = 1'b1;
			draw = repeat_more && ir.group == `GRP_DRAW;
		end
	end

	// Sequencer state and instruction register.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_reset)
		begin
			state <= ST_HALT;
			ir <= '0;
			sfx <= '0;
		end
		else
		begin
			unique case (state)
				ST_HALT:
					if (!status[`SR_HALT])
						state <= ST_FETCH;
				ST_FETCH:
					if (status[`SR_HALT])
						state <= ST_HALT;
					else if (fetch_done)
					begin
						state <= ST_EXEC;
						ir <= fetched;
						sfx <= fetched_sfx;
					end
				ST_EXEC:
					if (halt_set)
						state <= ST_HALT;
					else if (slow)
						state <= ST_SLOW;
					else if (sfx.rep)
						state <= ST_REPEAT;
					else
						state <= ST_FETCH;
				ST_SLOW:
					state <= sfx.rep ? ST_REPEAT : ST_FETCH;
				ST_REPEAT:
					if (!repeat_more)
						state <= ST_FETCH;
			endcase
		end
	end

	// Memory fetch request, addressed by the pointer of the current mode.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_reset)
		begin
			o_mem_req <= 1'b0;
			o_mem_addr <= '0;
		end
		else
		begin
			o_mem_req <= state == ST_FETCH && !fetch_done && !status[`SR_HALT];
			o_mem_addr <= from_read_ptr ? read_pointer_register : instruction_pointer;
		end
	end

	// Instruction pointer and read pointer.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_reset)
		begin
			instruction_pointer <= '0;
			read_pointer_register <= '0;
		end
		else
		begin
			if (fetch_done && from_read_ptr)
				read_pointer_register <= read_pointer_register + `COUNT_ONE;
			else if (fetch_done)
				instruction_pointer <= instruction_pointer + `COUNT_ONE;
			if (do_jump)
				instruction_pointer <= ir.data;
			if ((do_load && ir.reg_sel == `REG_READ_PTR) || (state == ST_EXEC && ir.group == `GRP_EXEC_AT))
				read_pointer_register <= ir.data;
		end
	end

	// Fetch mode after each instruction finishes.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_reset)
		begin
			o_mode <= MODE_SEQ;
			from_read_ptr <= 1'b0;
		end
		else if (state == ST_EXEC && !halt_set)
		begin
			if (sfx.rep)
				o_mode <= MODE_REPEAT;
			else if (sfx.exec && !sfx.seq)
			begin
				o_mode <= MODE_EXEC;
				from_read_ptr <= 1'b1;
			end
			else
			begin
				o_mode <= MODE_SEQ;
				from_read_ptr <= 1'b0;
			end
		end
		else if (state == ST_REPEAT && !repeat_more)
		begin
			o_mode <= (sfx.exec && !sfx.seq) ? MODE_EXEC : MODE_SEQ;
			from_read_ptr <= sfx.exec && !sfx.seq;
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_reset)
			o_draw_strobe <= 1'b0;
		else
			o_draw_strobe <= draw;
	end

	// Status register; later assignments win, so hardware sets beat clears.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_reset)
			status <= `SR_RESET_VALUE;
		else
		begin
			if (do_load && ir.reg_sel == `REG_STATUS)
				status <= ir.data;
			if (ir.cond != `SR_REPEAT_NEG && ir.cond != `SR_WORD_NEG)
			begin
				unique case (cond_op)
					`COND_RAISE:
						status[ir.cond] <= 1'b1;
					`COND_ZERO:
						status[ir.cond] <= 1'b0;
					`COND_INVERT:
						status[ir.cond] <= ~status[ir.cond];
					`COND_NONE:
						;
				endcase
			end
			if (repeat_changed)
				status[`SR_REPEAT_NEG] <= repeat_more;
			if (word_changed)
				status[`SR_WORD_NEG] <= word_more;
			if (i_area_update)
				status[`SR_AREA_OVERLAP] <= i_area_overlap;
			if (i_host_ctl_strobe && i_host_ctl.clear_hit)
				status[`SR_WINDOW_HIT] <= 1'b0;
			if (i_host_ctl_strobe && i_host_ctl.clear_halt)
				status[`SR_HALT] <= 1'b0;
			if (i_window_hit)
				status[`SR_WINDOW_HIT] <= 1'b1;
			if (halt_set || i_internal_halt)
				status[`SR_HALT] <= 1'b1;
		end
	end

	a_exec_entry: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(state == ST_EXEC && sfx.exec && !sfx.rep && !sfx.seq && !halt_set) |=> from_read_ptr && o_mode == MODE_EXEC)
		else $error("execute suffix did not enter execute mode");
	a_exec_noop: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(state == ST_EXEC && ir.group == `GRP_NOP && ir.cond == `NOP_PLAIN && ir.op == 4'h1)
		|=> $stable(instruction_pointer) && $stable(status[3:0]) && from_read_ptr)
		else $error("execute no-op did more than switch mode");
	a_exec_return: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(fetch_done && from_read_ptr) |=> $stable(instruction_pointer))
		else $error("execute fetch moved the instruction pointer");
	a_chain_step: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(state == ST_REPEAT && !repeat_more && sfx.exec && !sfx.seq) |=> state == ST_FETCH && from_read_ptr)
		else $error("repeat with execute suffix did not chain");
	a_loop_jump: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(state == ST_EXEC && ir.group == `GRP_LOOP && ir.op[1:0] == `LOOP_NEG_REPEAT && repeat_more)
		|=> instruction_pointer == $past(ir.data) && repeat_count == $past(repeat_count) + `COUNT_ONE)
		else $error("negative loop jump not taken with increment");
	a_loop_fall: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(state == ST_EXEC && ir.group == `GRP_LOOP && ir.op[1:0] == `LOOP_NEG_REPEAT
		&& repeat_count == `COUNT_MINUS_ONE) |=> repeat_count == `COUNT_ZERO && $stable(instruction_pointer))
		else $error("loop jump taken at minus one");
	a_repeat_hold: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(state == ST_REPEAT && repeat_more) |=> state == ST_REPEAT && o_mode == MODE_REPEAT)
		else $error("repeat ended early");
	a_seq_return: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(state == ST_EXEC && sfx.seq && !sfx.rep && !halt_set) |=> !from_read_ptr && o_mode == MODE_SEQ)
		else $error("sequential suffix did not return to normal");
	a_neg_track: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		repeat_changed |=> status[`SR_REPEAT_NEG] == $past(repeat_more))
		else $error("repeat-negative flag stale");
	a_zero_neg: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(state == ST_EXEC && ir.group == `GRP_COND && ir.cond == `SR_REPEAT_NEG && ir.op[1:0] == `COND_ZERO)
		|=> $stable(repeat_count))
		else $error("zeroing repeat-negative changed the count");
	a_hit_sticky: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		i_window_hit |=> status[`SR_WINDOW_HIT])
		else $error("window hit lost");
	a_halt_stop: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(state == ST_EXEC && halt_set) |=> state == ST_HALT ##1 !o_mem_req)
		else $error("halt did not stop fetching");

	c_repeat_run: cover property (@(posedge i_sys_clk) disable iff (i_reset)
		state == ST_REPEAT && repeat_more ##1 state == ST_REPEAT);
	c_exec_chain: cover property (@(posedge i_sys_clk) disable iff (i_reset)
		state == ST_REPEAT && !repeat_more && sfx.exec);
	c_loop_taken: cover property (@(posedge i_sys_clk) disable iff (i_reset)
		state == ST_EXEC && ir.group == `GRP_LOOP && take);
	c_halt: cover property (@(posedge i_sys_clk) disable iff (i_reset)
		state == ST_EXEC && halt_set);

endmodule // display_channel_sequencer_flags

// [dv/host_mem_model.sv]
// Behavioural host memory port that answers the sequencer's instruction fetches.
// Assumes the fetch request and address are held until the acknowledge is sampled.
`timescale 1ns/1ps
module host_mem_model
(
	input wire logic i_sys_clk,
	input wire logic i_mem_req,
	input wire logic [15:0] i_mem_addr,
	input wire logic [1:0] i_latency,
	output logic o_mem_ack,
	output logic [31:0] o_mem_rdata
);
	logic [31:0] mem [0:63];
	int fetches [0:63];
	int wait_cnt;
	initial
	begin
		o_mem_ack = 1'b0;
		o_mem_rdata = 32'h0000_0000;
		wait_cnt = 0;
		foreach (fetches[k])
			fetches[k] = 0;
	end
	// Answers after a variable stall; the data bus toggles whenever no word is handed over.
	always @(posedge i_sys_clk)
	begin
		o_mem_ack <= 1'b0;
		o_mem_rdata <= ~o_mem_rdata;
		if (i_mem_req && !o_mem_ack)
		begin
			if (wait_cnt == 0)
			begin
				o_mem_ack <= 1'b1;
				o_mem_rdata <= mem[i_mem_addr[5:0]];
				fetches[i_mem_addr[5:0]] <= fetches[i_mem_addr[5:0]] + 1;
				wait_cnt <= int'(i_latency);
			end
			else
				wait_cnt <= wait_cnt - 1;
		end
	end
endmodule // host_mem_model

// [dv/display_channel_sequencer_flags_tb_top.sv]
// Self-checking testbench of the channel sequencer and its condition status register.
// Assumes the host memory model beside it and the constants of the sequencer header.
`timescale 1ns/1ps
`include "dcsf_cfg.svh"
module display_channel_sequencer_flags_tb_top import dcsf_pkg::*;;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic mem_req, mem_ack, host_strobe, window_hit, area_update, area_overlap, internal_halt, draw_strobe;
	logic [15:0] mem_addr, status;
	logic [31:0] mem_rdata;
	logic [1:0] latency;
	host_ctl_t host_ctl;
	mode_t mode;
	int num_errors = 0;
	int checks_done = 0;
	int seed = 32'hba13;
	int draws = 0;
	logic seen_rep = 1'b0;
	logic seen_exec = 1'b0;
	always #2 sys_clk = ~sys_clk;
	display_channel_sequencer_flags i_dut (.i_sys_clk(sys_clk), .i_reset(reset), .o_mem_req(mem_req),
		.o_mem_addr(mem_addr), .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata), .i_host_ctl_strobe(host_strobe),
		.i_host_ctl(host_ctl), .i_window_hit(window_hit), .i_area_update(area_update),
		.i_area_overlap(area_overlap), .i_internal_halt(internal_halt), .o_status(status), .o_mode(mode),
		.o_draw_strobe(draw_strobe));
	host_mem_model i_mem (.i_sys_clk(sys_clk), .i_mem_req(mem_req), .i_mem_addr(mem_addr),
		.i_latency(latency), .o_mem_ack(mem_ack), .o_mem_rdata(mem_rdata));
	// Fetch stalls vary at random so the sequencer must wait on the acknowledge.
	always @(negedge sys_clk)
		latency <= 2'($random(seed));
	always @(posedge sys_clk)
	begin
		if (draw_strobe === 1'b1)
			draws <= draws + 1;
		if (mode === MODE_REPEAT)
			seen_rep <= 1'b1;
		if (mode === MODE_EXEC)
			seen_exec <= 1'b1;
	end
	function automatic logic [31:0] ins(input logic [3:0] g, input logic [3:0] op, input logic [3:0] cnd,
		input logic [2:0] rs, input logic [15:0] d);
		return {g, op, cnd, rs, 1'b0, d};
	endfunction
	// Negative loop jumps test before incrementing, so a count of -3 gives three passes.
	function automatic int loop_passes(input logic signed [15:0] c);
		int n;
		n = 1;
		while (c < -1)
		begin
			n++;
			c++;
		end
		return n;
	endfunction
	function automatic logic [15:0] status_exp(input logic overlap);
		logic [15:0] e;
		e = 16'h0000;
		e[`SR_USER_FLAG_0] = 1'b1;
		e[`SR_AREA_OVERLAP] = overlap;
		e[`SR_HALT] = 1'b1;
		return e;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] expected);
		checks_done++;
		if (seen !== expected)
		begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expected);
		end
	endtask
	task automatic host_word(input logic clr_halt, input logic clr_hit, input logic set_halt);
		@(negedge sys_clk);
		host_strobe = 1'b1;
		host_ctl = '{clear_halt: clr_halt, clear_hit: clr_hit};
		internal_halt = set_halt;
		@(negedge sys_clk);
		host_strobe = 1'b0;
		internal_halt = 1'b0;
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		num_errors++;
		conclude();
	end
	initial
	begin
		logic ov;
		host_strobe = 1'b0;
		host_ctl = '{clear_halt: 1'b0, clear_hit: 1'b0};
		window_hit = 1'b0;
		area_update = 1'b0;
		area_overlap = 1'b0;
		internal_halt = 1'b0;
		latency = 2'h0;
		for (int k = 0; k < 64; k++)
			i_mem.mem[k] = ins(`GRP_NOP, `NOP_PLAIN, 4'h1, 3'h0, 16'h0000);
		i_mem.mem[0] = ins(`GRP_COND, {2'h0, `COND_RAISE}, 4'h3, 3'h0, 16'h0000);
		i_mem.mem[1] = ins(`GRP_COND, {2'h0, `COND_INVERT}, 4'h0, 3'h0, 16'h0000);
		i_mem.mem[2] = ins(`GRP_COND, {2'h0, `COND_ZERO}, 4'h3, 3'h0, 16'h0000);
		i_mem.mem[3] = ins(`GRP_LOAD, 4'h0, 4'h0, `REG_REPEAT, 16'hFFFD);
		i_mem.mem[4] = ins(`GRP_LOOP, {2'h0, `LOOP_NEG_REPEAT}, 4'h0, 3'h0, 16'h0004);
		i_mem.mem[5] = ins(`GRP_LOAD, 4'h0, 4'h0, `REG_READ_PTR, 16'h0020);
		i_mem.mem[6] = ins(`GRP_LOAD, 4'h0, 4'h0, `REG_REPEAT, 16'hFFFC);
		i_mem.mem[7] = ins(`GRP_DRAW, 4'h3, 4'h0, `REG_WORD, 16'h0000);
		i_mem.mem[8] = ins(`GRP_NOP, 4'h1, 4'h0, 3'h0, 16'h0000);
		i_mem.mem[9] = ins(`GRP_COMBO, {2'h3, `COND_ZERO}, 4'h1, 3'h0, 16'h0010);
		i_mem.mem[32] = ins(`GRP_COND, {2'h0, `COND_RAISE}, 4'h1, 3'h0, 16'h0000);
		i_mem.mem[33] = ins(`GRP_NOP, 4'h4, 4'h0, 3'h0, 16'h0000);
		i_mem.mem[17] = ins(`GRP_LOAD, 4'h0, 4'h3, `REG_STATUS, 16'h8308);
		repeat (6) @(negedge sys_clk);
		reset = 1'b0;
		repeat (5) @(negedge sys_clk);
		check(32'(status), 32'h0000_8000);
		check(32'(mode), 32'h0000_0000);
		check(32'(mem_req), 32'h0000_0000);
		host_word(1'b1, 1'b0, 1'b0);
		check(32'(status[`SR_HALT]), 32'h0000_0000);
		$display("test reset_release done");
		for (int i = 0; i < 3000 && status[`SR_HALT] !== 1'b1; i++)
			@(negedge sys_clk);
		repeat (5) @(negedge sys_clk);
		check(32'(i_mem.fetches[4]), 32'(loop_passes(16'hFFFD)));
		check(32'(draws), 32'(-int'(signed'(16'hFFFC))));
		check(32'(seen_rep), 32'h0000_0001);
		check(32'(seen_exec), 32'h0000_0001);
		check(32'(i_mem.fetches[32]), 32'h0000_0001);
		check(32'(i_mem.fetches[33]), 32'h0000_0001);
		check(32'(i_mem.fetches[9]), 32'h0000_0001);
		check(32'(i_mem.fetches[10]), 32'h0000_0000);
		check(32'(i_mem.fetches[16]), 32'h0000_0001);
		check(32'(mem_req), 32'h0000_0000);
		check(32'(status), 32'(status_exp(1'b0)));
		$display("test program_run done");
		window_hit = 1'b1;
		@(negedge sys_clk);
		window_hit = 1'b0;
		repeat (3) @(negedge sys_clk);
		check(32'(status[`SR_WINDOW_HIT]), 32'h0000_0001);
		host_word(1'b0, 1'b1, 1'b0);
		check(32'(status[`SR_WINDOW_HIT]), 32'h0000_0000);
		host_word(1'b1, 1'b0, 1'b1);
		check(32'(status[`SR_HALT]), 32'h0000_0001);
		host_word(1'b1, 1'b0, 1'b0);
		repeat (20) @(negedge sys_clk);
		check(32'(status), 32'h0000_8308);
		ov = 1'($random(seed));
		area_overlap = ov;
		area_update = 1'b1;
		@(negedge sys_clk);
		area_update = 1'b0;
		check(32'(status), 32'(16'h8308 | (16'(ov) << `SR_AREA_OVERLAP)));
		$display("test clip_and_host done");
		conclude();
	end
endmodule // display_channel_sequencer_flags_tb_top
